// *** rtcifs_pkg.sv ***
package rtcifs_pkg;

   // Clock of the register side
   localparam int          CLK_FREQ_KHZ   = 200000;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  FLAG_IDX       = 8'h0E;
   localparam logic [7:0]  CTRL_IDX       = 8'h0F;
   localparam logic [7:0]  CFG_IDX        = 8'h10;
   localparam int          ADDR_W         = 8;
   localparam int          IDX_LSB        = 2;

   // Flag register fields
   localparam int          UF_BIT         = 5;
   localparam int          TF_BIT         = 4;
   localparam int          AF_BIT         = 3;
   localparam int          VLF_BIT        = 1;
   localparam int          COMPENSATION_STOP_FLAG_BIT       = 0;
   localparam logic [7:0]  FLAG_MASK      = 8'h3B;
   localparam logic [7:0]  FLAG_RST       = 8'h03;

   // Control register fields
   localparam int          CSEL_HI_BIT    = 7;
   localparam int          CSEL_LO_BIT    = 6;
   localparam int          UIE_BIT        = 5;
   localparam int          TIE_BIT        = 4;
   localparam int          AIE_BIT        = 3;
   localparam int          STOP_BIT       = 0;
   localparam logic [7:0]  CTRL_MASK      = 8'hF9;
   localparam logic [7:0]  CTRL_RST       = 8'h40;

   // Extra configuration register: timer source select
   localparam logic [7:0]  CFG_MASK       = 8'h03;
   localparam logic [7:0]  CFG_RST        = 8'h00;

   // Timer source selections
   localparam logic [1:0]  TSRC_4096      = 2'h0;
   localparam logic [1:0]  TSRC_64        = 2'h1;
   localparam logic [1:0]  TSRC_SEC       = 2'h2;
   localparam logic [1:0]  TSRC_MIN       = 2'h3;

   // Divider chain: stages above the fast ones are held while stopped
   localparam int          DIV_W          = 15;
   localparam int          DIV_FAST_W     = 3;
   localparam int          DIV_64_W       = 9;

   // Automatic release of update and timer interrupt pulses
   localparam real         IRQ_PULSE_MS   = 7.8;
   localparam int          IRQ_PULSE_CYC  = $rtoi(IRQ_PULSE_MS * CLK_FREQ_KHZ);

   // AXI responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// *** rtcifs_pulse.sv ***
`timescale 1ns/1ps
// One-shot interrupt request that releases itself after a fixed time
module rtcifs_pulse
   import rtcifs_pkg::*;
#(
   parameter int CYCLES = IRQ_PULSE_CYC
)
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Trigger and enable
   input  wire logic trig,
   input  wire logic en,
   // Request level
   output logic      active
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;   // Cycles spent active
   logic          act_q;   // Request held

   // Start on an enabled event, end on timeout or on enable cleared
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         act_q <= 1'b0;
         cnt_q <= '0;
      end
      else if (!en)
      begin
         act_q <= 1'b0;
         cnt_q <= '0;
      end
      else if (trig)
      begin
         act_q <= 1'b1;
         cnt_q <= '0;
      end
      else if (act_q && cnt_q == LAST)
      begin
         act_q <= 1'b0;
      end
      else if (act_q)
      begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign active = act_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_pulse_bound;
      act_q |-> cnt_q <= LAST;
   endproperty
   a_pulse_bound: assert property (p_pulse_bound) else $error("pulse exceeds release time");

   property p_pulse_end;
      act_q && en && !trig && cnt_q == LAST |=> !act_q;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse not released");

endmodule

// *** rtcifs_core.sv ***
`timescale 1ns/1ps
// How it works
// - alarm flag with enable pulls interrupt low
// - clearing alarm enable releases the interrupt
// - alarm interrupt holds until flag cleared
// - interrupt is OR of three requests
// - stop bit halts counting, clears sub-second
// - bus stop during timeout clears stop bit
// - clearing stop bit restarts operation
// - stopped: no updates, no update/alarm events
// - stopped timer runs only on fastest source
// - stopped: divider 2048 Hz to 1 Hz held
// - flag register bit layout, unused read zero
// - update flag sticky until written zero
// - timer flag sticky until written zero
// - alarm flag sticky until written zero
// - data loss flag sticky until written zero
// - reset: loss and comp-stop flags read one
// - writing one to a flag does nothing
// - update/timer pulse auto-release after 7.8 ms
// - control register bit layout
// - compensation stop flag sticky until zero
module rtcifs_core
   import rtcifs_pkg::*;
#(
   parameter int PULSE_CYCLES = IRQ_PULSE_CYC
)
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Oscillator from outside the clock domain
   input  wire logic        osc_clk,
   // Events from counters and supply monitors
   input  wire logic        update_evt,
   input  wire logic        timer_evt,
   input  wire logic        alarm_evt,
   input  wire logic        minute_evt,
   input  wire logic        data_loss_evt,
   input  wire logic        comp_stop_evt,
   // Serial bus front end
   input  wire logic        bus_stop_evt,
   input  wire logic        bus_timeout_active,
   // Interrupt pin, open drain
   output logic             irq_n_o,
   output logic             irq_oe,
   // Ticks to counters and status
   output logic             sec_tick,
   output logic             timer_src_tick,
   output logic             stopped,
   output logic [1:0]       comp_interval_sel
);

   // Address decode shared by reads and writes
   function automatic logic [2:0] reg_sel(input logic [7:0] addr);
      logic [7:0] idx;
      idx = {2'h0, addr[ADDR_W-1:IDX_LSB]};
      reg_sel = {idx == CFG_IDX, idx == CTRL_IDX, idx == FLAG_IDX};
   endfunction

   logic [7:0]       flags_q;     // Sticky event flags
   logic [7:0]       ctrl_q;      // Enables, compensation select, stop
   logic [7:0]       cfg_q;       // Timer source select
   logic [7:0]       awaddr_q;    // Held write address
   logic             aw_full_q;   // Write address taken
   logic [31:0]      wdata_q;     // Held write data
   logic             wstrb0_q;    // Low byte lane enabled
   logic             w_full_q;    // Write data taken
   logic [2:0]       osc_sync_q;  // Synchroniser and edge history
   logic [DIV_W-1:0] div_q;       // Divider chain
   logic             irq_oe_q;    // Pin driven low
   logic             sec_tick_q;  // 1 Hz tick out
   logic             tsrc_q;      // Selected timer source tick
   logic             upd_act;     // Update pulse request
   logic             tmr_act;     // Timer pulse request
   logic             wr_go;       // Write performed this cycle
   logic [2:0]       wr_sel;      // Written register
   logic             osc_rise;    // Oscillator edge
   logic             tick_4096;   // Fast stage wrap
   logic             tick_64;     // 64 Hz wrap
   logic             tick_1hz;    // 1 Hz wrap
   logic             slow_src;    // Timer on a stoppable source
   logic             upd_g;       // Update event passing stop
   logic             alm_g;       // Alarm event passing stop
   logic             tmr_g;       // Timer event passing stop
   logic [7:0]       flag_set;    // Hardware sets
   logic [7:0]       flag_clr;    // Host clears
   logic             irq_req;     // Combined request
   logic             tsrc_d;      // Next timer source tick

   // Write channel: address and data taken in either order
   assign wr_go  = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_sel = reg_sel(awaddr_q);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb0_q  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_full_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         else if (wr_go)
            w_full_q <= 1'b0;
      end
   end

   // Ready while the slot is empty and no response waits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_full_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one-cycle answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= (reg_sel(s_axi_araddr) == 3'h0) ? RESP_SLVERR : RESP_OKAY;
            unique case (reg_sel(s_axi_araddr))
               3'h1:    s_axi_rdata <= {24'h000000, flags_q & FLAG_MASK};
               3'h2:    s_axi_rdata <= {24'h000000, ctrl_q & CTRL_MASK};
               3'h4:    s_axi_rdata <= {24'h000000, cfg_q & CFG_MASK};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Control register, with stop cancelled by the bus on timeout
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= CTRL_RST;
         cfg_q  <= CFG_RST;
      end
      else if (wr_go && wstrb0_q && wr_sel[1])
         ctrl_q <= wdata_q[7:0] & CTRL_MASK;
      else
      begin
         if (wr_go && wstrb0_q && wr_sel[2])
            cfg_q <= wdata_q[7:0] & CFG_MASK;
         if (bus_stop_evt && bus_timeout_active)
            ctrl_q[STOP_BIT] <= 1'b0;
      end
   end

   // Oscillator synchroniser; stages two and three feed the edge detect
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         osc_sync_q <= 3'h0;
      else
         osc_sync_q <= {osc_sync_q[1:0], osc_clk};
   end
   assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];

   // Divider wraps
   assign tick_4096 = osc_rise && (&div_q[DIV_FAST_W-1:0]);
   assign tick_64   = osc_rise && (&div_q[DIV_64_W-1:0]);
   assign tick_1hz  = osc_rise && (&div_q);

   // Divider chain: upper stages held in reset while stopped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_q <= '0;
      else
      begin
         if (osc_rise)
            div_q <= div_q + 1'b1;
         if (ctrl_q[STOP_BIT])
            div_q[DIV_W-1:DIV_FAST_W] <= '0;
      end
   end

   // Event gating by the stop state
   assign slow_src = cfg_q[1:0] != TSRC_4096;
   assign upd_g    = update_evt && !ctrl_q[STOP_BIT];
   assign alm_g    = alarm_evt && !ctrl_q[STOP_BIT];
   assign tmr_g    = timer_evt && !(ctrl_q[STOP_BIT] && slow_src);

   // Timer source selection
   always_comb
   begin
      case (cfg_q[1:0])
         TSRC_4096: tsrc_d = tick_4096;
         TSRC_64:   tsrc_d = tick_64;
         TSRC_SEC:  tsrc_d = tick_1hz;
         TSRC_MIN:  tsrc_d = minute_evt;
         default:   tsrc_d = 1'b0;
      endcase
      if (ctrl_q[STOP_BIT] && slow_src)
         tsrc_d = 1'b0;
   end

   // Ticks to counters
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sec_tick_q <= 1'b0;
         tsrc_q     <= 1'b0;
      end
      else
      begin
         sec_tick_q <= tick_1hz && !ctrl_q[STOP_BIT];
         tsrc_q     <= tsrc_d;
      end
   end

   // Flag sets and host clears; only a written zero clears
   always_comb
   begin
      flag_set           = 8'h00;
      flag_set[UF_BIT]   = upd_g;
      flag_set[TF_BIT]   = tmr_g;
      flag_set[AF_BIT]   = alm_g;
      flag_set[VLF_BIT]  = data_loss_evt;
      flag_set[COMPENSATION_STOP_FLAG_BIT] = comp_stop_evt;
      flag_clr           = 8'h00;
      if (wr_go && wstrb0_q && wr_sel[0])
         flag_clr = ~wdata_q[7:0] & FLAG_MASK;
   end

   // Sticky flags; a set beats a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_q <= FLAG_RST;
      else
         flags_q <= ((flags_q & ~flag_clr) | flag_set) & FLAG_MASK;
   end

   // Self-releasing update and timer requests
   rtcifs_pulse #(.CYCLES(PULSE_CYCLES)) u_upd_pulse
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .trig    (upd_g),
      .en      (ctrl_q[UIE_BIT]),
      .active  (upd_act)
   );

   rtcifs_pulse #(.CYCLES(PULSE_CYCLES)) u_tmr_pulse
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .trig    (tmr_g),
      .en      (ctrl_q[TIE_BIT]),
      .active  (tmr_act)
   );

   // Alarm request holds as long as flag and enable
   assign irq_req = upd_act || tmr_act || (flags_q[AF_BIT] && ctrl_q[AIE_BIT]);

   // Open-drain pin: low driven while requested, else released
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_oe_q <= 1'b0;
         irq_n_o  <= 1'b0;
      end
      else
      begin
         irq_oe_q <= irq_req;
         irq_n_o  <= 1'b0;
      end
   end

   assign irq_oe            = irq_oe_q;
   assign sec_tick          = sec_tick_q;
   assign timer_src_tick    = tsrc_q;
   assign stopped           = ctrl_q[STOP_BIT];
   assign comp_interval_sel = ctrl_q[CSEL_HI_BIT:CSEL_LO_BIT];

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_alarm_irq;
      flags_q[AF_BIT] && ctrl_q[AIE_BIT] |=> irq_oe_q;
   endproperty
   a_alarm_irq: assert property (p_alarm_irq) else $error("alarm did not pull pin low");

   property p_all_off;
      (!ctrl_q[AIE_BIT] && !ctrl_q[UIE_BIT] && !ctrl_q[TIE_BIT]) [*2] |=> !irq_oe_q;
   endproperty
   a_all_off: assert property (p_all_off) else $error("pin driven with enables clear");

   property p_alarm_hold;
      flags_q[AF_BIT] && ctrl_q[AIE_BIT] && !flag_clr[AF_BIT] && !(wr_go && wr_sel[1]) |=> flags_q[AF_BIT] ##1 irq_oe_q;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm released itself");

   property p_update_or;
      upd_act |=> irq_oe_q;
   endproperty
   a_update_or: assert property (p_update_or) else $error("update request missing on pin");

   property p_bus_cancel;
      bus_stop_evt && bus_timeout_active && !(wr_go && wr_sel[1]) |=> !ctrl_q[STOP_BIT];
   endproperty
   a_bus_cancel: assert property (p_bus_cancel) else $error("stop not cancelled by bus");

   property p_stop_div;
      ctrl_q[STOP_BIT] |=> div_q[DIV_W-1:DIV_FAST_W] == '0 && !sec_tick_q;
   endproperty
   a_stop_div: assert property (p_stop_div) else $error("divider ran while stopped");

   property p_stop_timer;
      ctrl_q[STOP_BIT] && slow_src |=> !tsrc_q;
   endproperty
   a_stop_timer: assert property (p_stop_timer) else $error("slow timer source ran while stopped");

   property p_stop_update;
      ctrl_q[STOP_BIT] && !flags_q[UF_BIT] |=> !flags_q[UF_BIT];
   endproperty
   a_stop_update: assert property (p_stop_update) else $error("update flag set while stopped");

   property p_set_wins;
      upd_g |=> flags_q[UF_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("update event lost");

   property p_write_one;
      flags_q[VLF_BIT] && !flag_clr[VLF_BIT] |=> flags_q[VLF_BIT];
   endproperty
   a_write_one: assert property (p_write_one) else $error("data loss flag cleared without zero");

   c_alarm_irq:   cover property (flags_q[AF_BIT] && ctrl_q[AIE_BIT] ##1 irq_oe_q);
   c_bus_cancel:  cover property (ctrl_q[STOP_BIT] ##1 !ctrl_q[STOP_BIT]);
   c_set_and_clr: cover property (upd_g && flag_clr[UF_BIT]);

endmodule

// *** rtcifs_src_model.sv ***
`timescale 1ns/1ps
// Oscillator and event sources on the far side of the block
module rtcifs_src_model
   import rtcifs_pkg::*;
(
   // Register clock
   input  wire logic aclk,
   // Free-running crystal and event pulses
   output logic       osc_clk,
   output logic [6:0] evt
);
   // Crystal runs free, 48 ns period
   initial
   begin
      osc_clk = 1'b0;
      forever #24 osc_clk = ~osc_clk;
   end
   // No event pending at start
   initial evt = 7'h00;
   // One-cycle pulse: 0 update, 1 timer, 2 alarm, 3 minute, 4 loss, 5 comp, 6 bus stop
   task automatic pulse(input int i);
      @(posedge aclk);
      evt <= 7'h01 << i;
      @(posedge aclk);
      evt <= 7'h00;
   endtask
endmodule

// *** rtc_interrupt_flags_and_stop_tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for flags, interrupt pin and stop control
module rtc_interrupt_flags_and_stop_tb_top;
   import rtcifs_pkg::*;
   localparam int         PULSE = 20;
   localparam int         LIMIT = 30000;
   localparam logic [7:0] A_FLG = FLAG_IDX << IDX_LSB;
   localparam logic [7:0] A_CTL = CTRL_IDX << IDX_LSB;
   localparam logic [7:0] A_CFG = CFG_IDX << IDX_LSB;
   localparam logic [7:0] A_BAD = 8'h44;
   // Bus and pin signals
   logic        aclk, aresetn, tmo;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, csel;
   logic        osc_clk, irq_n, irq_oe, sec_tick, tsrc_tick, stopped;
   logic [6:0]  evt;
   int          n_errors, cmp_count, cyc;

   // Device under test with a short interrupt pulse
   rtcifs_core #(.PULSE_CYCLES(PULSE)) uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_clk(osc_clk), .update_evt(evt[0]), .timer_evt(evt[1]), .alarm_evt(evt[2]),
      .minute_evt(evt[3]), .data_loss_evt(evt[4]), .comp_stop_evt(evt[5]),
      .bus_stop_evt(evt[6]), .bus_timeout_active(tmo),
      .irq_n_o(irq_n), .irq_oe(irq_oe), .sec_tick(sec_tick), .timer_src_tick(tsrc_tick),
      .stopped(stopped), .comp_interval_sel(csel));

   // Far-side sources
   rtcifs_src_model src (.aclk(aclk), .osc_clk(osc_clk), .evt(evt));

   // 200 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Prints the verdict and ends the run
   task automatic give_verdict;
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_errors++;
         give_verdict;
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // Register write; handshakes judged at the falling edge before the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      hb = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb)
      begin
         @(negedge aclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         if (hb)
            chk({30'h0, bresp}, {30'h0, er});
         @(posedge aclk);
         if (ha)
            awvalid <= 1'b0;
         if (hw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   // Register read with expected low byte and response
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
      logic hr, hd;
      hd = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hd)
      begin
         @(negedge aclk);
         hr = arvalid & arready;
         hd = rvalid;
         if (hd)
         begin
            chk(rdata, {24'h000000, exp});
            chk({30'h0, rresp}, {30'h0, er});
         end
         @(posedge aclk);
         if (hr)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   // Interrupt pin state after n edges; pin data is low whenever driven
   task automatic irq_is(input int n, input logic e);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, irq_oe}, {31'h0, e});
      if (e)
         chk({31'h0, irq_n}, 32'h0);
   endtask

   // Tick count over n cycles
   task automatic ticks(input int n, output logic [31:0] t, output logic [31:0] s);
      t = 0;
      s = 0;
      repeat (n)
      begin
         @(negedge aclk);
         t += tsrc_tick;
         s += sec_tick;
      end
   endtask

   // Reset values, layouts, low byte lane off and unmapped access
   task automatic t_reset;
      rd(A_FLG, 8'h03, RESP_OKAY);
      rd(A_CTL, 8'h40, RESP_OKAY);
      chk({30'h0, csel}, 32'h1);
      rd(A_BAD, 8'h00, RESP_SLVERR);
      wstrb <= 4'hE;
      wr(A_CTL, 8'hFF, RESP_OKAY);
      wstrb <= 4'hF;
      rd(A_CTL, 8'h40, RESP_OKAY);
      wr(A_BAD, 8'hFF, RESP_SLVERR);
      irq_is(0, 1'b0);
      wr(A_CTL, 8'hFF, RESP_OKAY);
      rd(A_CTL, 8'hF9, RESP_OKAY);
      chk({30'h0, csel}, 32'h3);
      wr(A_CTL, 8'h40, RESP_OKAY);
   endtask

   // Sticky flags: ones ignored, zero clears, events set
   task automatic t_flags;
      wr(A_FLG, 8'hFF, RESP_OKAY);
      rd(A_FLG, 8'h03, RESP_OKAY);
      wr(A_FLG, 8'h00, RESP_OKAY);
      rd(A_FLG, 8'h00, RESP_OKAY);
      src.pulse(4);
      rd(A_FLG, 8'h02, RESP_OKAY);
      src.pulse(5);
      rd(A_FLG, 8'h03, RESP_OKAY);
      wr(A_FLG, 8'h00, RESP_OKAY);
   endtask

   // Alarm interrupt: enable gating, no self release, cancel by enable and flag
   task automatic t_alarm;
      src.pulse(2);
      irq_is(3, 1'b0);
      rd(A_FLG, 8'h08, RESP_OKAY);
      wr(A_CTL, 8'h48, RESP_OKAY);
      irq_is(3, 1'b1);
      wr(A_FLG, 8'h00, RESP_OKAY);
      irq_is(2, 1'b0);
      src.pulse(2);
      irq_is(2, 1'b1);
      irq_is(60, 1'b1);
      rd(A_FLG, 8'h08, RESP_OKAY);
      wr(A_CTL, 8'h40, RESP_OKAY);
      irq_is(2, 1'b0);
      wr(A_CTL, 8'h48, RESP_OKAY);
      irq_is(2, 1'b1);
      wr(A_FLG, 8'h00, RESP_OKAY);
      irq_is(2, 1'b0);
      wr(A_CTL, 8'h40, RESP_OKAY);
   endtask

   // Update or timer event: timed pulse on its own enable, sticky flag
   task automatic t_pulse(input int i, input logic [7:0] en, input logic [7:0] f);
      wr(A_CTL, en ^ 8'h30, RESP_OKAY);
      src.pulse(i);
      irq_is(2, 1'b0);
      wr(A_FLG, 8'h00, RESP_OKAY);
      wr(A_CTL, en, RESP_OKAY);
      src.pulse(i);
      irq_is(2, 1'b1);
      irq_is(PULSE - 2, 1'b1);
      irq_is(2, 1'b0);
      rd(A_FLG, f, RESP_OKAY);
      wr(A_FLG, 8'h00, RESP_OKAY);
      wr(A_CTL, 8'h40, RESP_OKAY);
   endtask

   // Stop bit: frozen events and divider, fast timer source, bus cancel, restart
   task automatic t_stop;
      logic [31:0] t, s;
      wr(A_CTL, 8'h41, RESP_OKAY);
      chk({31'h0, stopped}, 32'h1);
      src.pulse(0);
      src.pulse(2);
      wr(A_CFG, 8'h01, RESP_OKAY);
      src.pulse(1);
      rd(A_FLG, 8'h00, RESP_OKAY);
      ticks(6000, t, s);
      chk(t, 0);
      chk(s, 0);
      wr(A_CFG, 8'h00, RESP_OKAY);
      src.pulse(1);
      rd(A_FLG, 8'h10, RESP_OKAY);
      ticks(400, t, s);
      chk({31'h0, t > 2}, 32'h1);
      wr(A_FLG, 8'h00, RESP_OKAY);
      src.pulse(6);
      irq_is(1, 1'b0);
      chk({31'h0, stopped}, 32'h1);
      @(posedge aclk);
      tmo <= 1'b1;
      src.pulse(6);
      tmo <= 1'b0;
      irq_is(2, 1'b0);
      chk({31'h0, stopped}, 32'h0);
      wr(A_CTL, 8'h41, RESP_OKAY);
      wr(A_CTL, 8'h40, RESP_OKAY);
      chk({31'h0, stopped}, 32'h0);
      src.pulse(0);
      rd(A_FLG, 8'h20, RESP_OKAY);
      wr(A_FLG, 8'h00, RESP_OKAY);
      // Minute source: one tick per minute event while running, none while stopped
      wr(A_CFG, 8'h03, RESP_OKAY);
      rd(A_CFG, 8'h03, RESP_OKAY);
      src.pulse(3);
      ticks(3, t, s);
      chk(t, 1);
      wr(A_CTL, 8'h41, RESP_OKAY);
      src.pulse(3);
      ticks(3, t, s);
      chk(t, 0);
      wr(A_CTL, 8'h40, RESP_OKAY);
      wr(A_CFG, 8'h02, RESP_OKAY);
      rd(A_CFG, 8'h02, RESP_OKAY);
   endtask

   // Main sequence
   initial
   begin
      n_errors = 0;
      cmp_count = 0;
      cyc = 0;
      aresetn = 1'b0;
      tmo = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_flags;
      t_alarm;
      t_pulse(0, 8'h60, 8'h20);
      t_pulse(1, 8'h50, 8'h10);
      t_stop;
      give_verdict;
   end
endmodule
